// >>> pkg/vt_pkg.sv
`default_nettype none

package vt_pkg;

	// ****************************************
	// Clock and programming times
	// ****************************************
	localparam int CLK_MHZ      = 125;
	localparam int T_WR_US      = 5000;
	localparam int T_LOCK_US    = 5000;
	localparam int T_WAFI_US    = 5000;
	localparam int T_LAFI_US    = 5000;
	localparam int T_WDSFID_US  = 5000;
	localparam int T_LDSFID_US  = 5000;
	localparam int T_EAS_US     = 5000;
	localparam int WR_CYC       = T_WR_US * CLK_MHZ;
	localparam int LOCK_CYC     = T_LOCK_US * CLK_MHZ;
	localparam int WAFI_CYC     = T_WAFI_US * CLK_MHZ;
	localparam int LAFI_CYC     = T_LAFI_US * CLK_MHZ;
	localparam int WDSFID_CYC   = T_WDSFID_US * CLK_MHZ;
	localparam int LDSFID_CYC   = T_LDSFID_US * CLK_MHZ;
	localparam int EAS_CYC      = T_EAS_US * CLK_MHZ;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int RX_DEPTH     = 16;
	localparam int FRAME_MAX    = 7;
	localparam int NUM_BLOCKS   = 32;
	localparam int BLK_PER_PAGE = 4;
	localparam int HDR_BYTES    = 2;
	localparam int UID_BYTES    = 8;
	localparam int MIN_FRAME    = 4;
	localparam int FLG_ERR      = 0;
	localparam int FLG_ADDR     = 5;
	localparam int FLG_OPT      = 6;
	localparam int PROT_RD      = 0;
	localparam int PROT_WR      = 1;
	localparam logic [7:0] CUSTOM_BASE = 8'ha0;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OPC_INVENTORY = 8'h01;
	localparam logic [7:0] OPC_LOGIN     = 8'he4;

	// ****************************************
	// Error codes and CRC
	// ****************************************
	localparam logic [7:0]  ERR_GENERIC = 8'h0f;
	localparam logic [7:0]  ERR_RANGE   = 8'h10;
	localparam logic [7:0]  ERR_ALREADY = 8'h11;
	localparam logic [7:0]  ERR_LOCKED  = 8'h12;
	localparam logic [15:0] CRC_INIT    = 16'hffff;
	localparam logic [15:0] CRC_POLY    = 16'h8408;
	localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;

	// ****************************************
	// Register map and reset values
	// ****************************************
	localparam logic [7:0]  OFF_STATUS = 8'h00;
	localparam logic [7:0]  OFF_PWD    = 8'h04;
	localparam logic [7:0]  OFF_LOCKS  = 8'h08;
	localparam logic [7:0]  OFF_PROT   = 8'h0c;
	localparam logic [7:0]  OFF_IDENT  = 8'h10;
	localparam logic [31:0] PWD_RST    = 32'h0000_0000;
	localparam logic [7:0]  AFI_RST    = 8'h00;
	localparam logic [7:0]  DSFID_RST  = 8'h00;

	typedef enum {OP_NONE, OP_PLAIN, OP_READ, OP_WRITE, OP_LOCK, OP_WAFI, OP_LAFI,
		OP_WDSF, OP_LDSF, OP_PROG, OP_PROT, OP_LOGIN} vt_op_type;
	typedef enum {ST_IDLE, ST_RECV, ST_EXEC, ST_PROG, ST_EOF, ST_SEND} vt_state_type;

	// Opcode to command class
	function automatic vt_op_type op_class(input logic [7:0] opc);
		unique case (opc)
			8'h01, 8'h23, 8'h2b, 8'h2c, 8'ha5, 8'hb0, 8'hb8, 8'hc3: return OP_PLAIN;
			8'hb4, 8'hb9, 8'hba, 8'hbb, 8'hbe, 8'hbf:               return OP_PLAIN;
			8'h20: return OP_READ;
			8'h21: return OP_WRITE;
			8'h22: return OP_LOCK;
			8'h27: return OP_WAFI;
			8'h28: return OP_LAFI;
			8'h29: return OP_WDSF;
			8'h2a: return OP_LDSF;
			8'ha2, 8'ha3, 8'ha4, 8'ha6, 8'ha7, 8'ha8: return OP_PROG;
			8'hb6: return OP_PROT;
			8'he4: return OP_LOGIN;
			default: return OP_NONE;
		endcase
	endfunction

	// Commands executed only in secure mode
	function automatic logic sec_only(input logic [7:0] opc);
		return opc inside {8'ha6, 8'hb4, 8'hb6, 8'hb9, 8'hba, 8'hbb, 8'hbe, 8'hbf};
	endfunction

	// One byte through the reflected frame CRC
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

endpackage

`default_nettype wire

// >>> hw/vt_crc16.sv
`default_nettype none

module vt_crc16 (
	input  wire logic        pclk,    // Clock
	input  wire logic        presetn, // Async reset, low
	input  wire logic        init,    // Restart at frame start
	input  wire logic        en,      // Byte strobe
	input  wire logic [7:0]  din,     // Byte, LSB first on air
	output logic      [15:0] crc      // Running register
);

	logic [15:0] crc_q;

	// Running CRC register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_q <= vt_pkg::CRC_INIT;
		end else if (init) begin
			crc_q <= vt_pkg::CRC_INIT;
		end else if (en) begin
			crc_q <= vt_pkg::crc_byte(crc_q, din);
		end
	end

	assign crc = crc_q;

endmodule

`default_nettype wire

// >>> hw/vt_prog_timer.sv
`default_nettype none

module vt_prog_timer #(
	parameter int W = 32
) (
	input  wire logic         pclk,    // Clock
	input  wire logic         presetn, // Async reset, low
	input  wire logic         load,    // Start a wait
	input  wire logic [W-1:0] count,   // Cycles to wait, at least one
	output logic              done,    // Last cycle of the wait
	output logic              busy     // Wait running
);

	logic [W-1:0] cnt_q;

	// Down counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= count;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

	assign busy = (cnt_q != '0);
	assign done = (cnt_q == W'(1));

endmodule

`default_nettype wire

// >>> hw/vt_cmd_core.sv
// Notes on behaviour
// [RL1] Decode read, write, lock, read multiple and block security status opcodes.
// [RL2] Decode write/lock AFI, write/lock DSFID and system information opcodes.
// [RL3] Decode the custom security opcodes B0 to BF; the code decodes only B0, B4, B6, B8 to BB, BE and BF.
// [RL4] Decode fast read multiple blocks and password login.
// [RL5] Decode the seven surveillance custom opcodes A2 to A8.
// [RL6] Reader sends flags, opcode, parameters and CRC between SOF and EOF.
// [RL7] Answer is flags, optional parameters and CRC, in both modes.
// [RL8] Error flag clear on success; else set with an error code byte.
// [RL9] Reader checks results itself; the tag never verifies its own writes.
// [RL10] Inventory is accepted in normal and secure mode alike.
// [RL11] Block write without option flag answers after the block programming time.
// [RL12] With option flag, reader waits block programming time before EOF.
// [RL13] With option flag, programming answers are held until the reader's EOF.
// [RL14] Writing a permanently locked block answers with the error flag.
// [RL15] Normal mode write into a write-protected page answers with error.
// [RL16] Secure mode ignores page protection but still honours block locks.
// [RL17] Lock block without option flag answers after lock programming time.
// [RL18] With option flag, reader waits lock programming time before EOF.
// [RL19] Write AFI answers after its time; with option flag reader waits.
// [RL20] Lock AFI answers after its time; with option flag reader waits.
// [RL21] Write DSFID answers after its time; with option flag reader waits.
// [RL22] Secure mode ends only at reset or on a wrong-password login.
// [RL23] A request failing its CRC is dropped with no state change.
//
// Design decisions made here: register access over APB and the register offsets.
`default_nettype none

module vt_cmd_core #(
	parameter int NUM_BLOCKS = vt_pkg::NUM_BLOCKS,
	parameter int WR_CYC     = vt_pkg::WR_CYC,
	parameter int LOCK_CYC   = vt_pkg::LOCK_CYC,
	parameter int WAFI_CYC   = vt_pkg::WAFI_CYC,
	parameter int LAFI_CYC   = vt_pkg::LAFI_CYC,
	parameter int WDSF_CYC   = vt_pkg::WDSFID_CYC,
	parameter int LDSF_CYC   = vt_pkg::LDSFID_CYC,
	parameter int EAS_CYC    = vt_pkg::EAS_CYC
) (
	input  wire logic        pclk,      // Clock, 125 MHz
	input  wire logic        presetn,   // Async reset, low
	input  wire logic [7:0]  paddr,     // APB address
	input  wire logic        psel,      // APB select
	input  wire logic        penable,   // APB enable
	input  wire logic        pwrite,    // APB direction
	input  wire logic [31:0] pwdata,    // APB write data
	output logic      [31:0] prdata,    // APB read data
	output logic             pready,    // APB ready
	output logic             pslverr,   // APB error, unmapped
	input  wire logic        rx_sof,    // Request start
	input  wire logic        rx_valid,  // Request byte strobe
	input  wire logic [7:0]  rx_byte,   // Request byte
	input  wire logic        rx_eof,    // Request or option EOF
	output logic             tx_valid,  // Answer byte valid
	output logic      [7:0]  tx_byte,   // Answer byte
	output logic             tx_last,   // Final answer byte
	input  wire logic        tx_ready,  // Modulator takes byte
	output logic      [7:0]  mem_addr,  // Block address
	input  wire logic [31:0] mem_rdata, // Block data, next cycle
	output logic             mem_we,    // Block write pulse
	output logic      [31:0] mem_wdata  // Block write data
);

	localparam int IW     = $clog2(vt_pkg::RX_DEPTH);
	localparam int LBW    = $clog2(NUM_BLOCKS);
	localparam int PROT_W = 2 * NUM_BLOCKS / vt_pkg::BLK_PER_PAGE;

	vt_pkg::vt_state_type state_q;
	vt_pkg::vt_op_type    op;
	logic [7:0]        buf_q [vt_pkg::RX_DEPTH];
	logic [IW:0]       cnt_q;
	logic [7:0]        frame_q [vt_pkg::FRAME_MAX];
	logic [7:0]        frame_d [vt_pkg::FRAME_MAX];
	logic [2:0]        flen_q, flen_d, idx_q;
	logic [7:0]        tx_byte_q, code_d, last_op_q, last_code_q, blk, afi_q, dsfid_q;
	logic [7:0]        flags, opc;
	logic [31:0]       wdat, pwd_q, prdata_q, prog_d, prog_len_q, wait_cnt_q;
	logic [NUM_BLOCKS-1:0] lock_q;
	logic [PROT_W-1:0] prot_q;
	logic [IW:0]       p;
	logic [15:0]       rx_crc, crc_d;
	logic              secure_q, afi_lk_q, dsf_lk_q, last_err_q, err_d, in_range;
	logic              locked, wp, rp, opt, crc_ok, accept, tmr_done, mem_we_q;
	logic              apb_wr, apb_setup, exec_ok;

	// Byte fetch with bound check
	function automatic logic [7:0] bt(input logic [IW:0] i);
		return (i < (IW+1)'(vt_pkg::RX_DEPTH)) ? buf_q[i[IW-1:0]] : 8'h00;
	endfunction

	// Mapped register offsets
	function automatic logic hit(input logic [7:0] a);
		return a inside {vt_pkg::OFF_STATUS, vt_pkg::OFF_PWD, vt_pkg::OFF_LOCKS,
			vt_pkg::OFF_PROT, vt_pkg::OFF_IDENT};
	endfunction

	// ****************************************
	// Request parsing
	// ****************************************
	// [RL6] request field layout
	always_comb begin
		flags  = buf_q[0];
		opc    = buf_q[1];
		opt    = flags[vt_pkg::FLG_OPT];
		p      = (IW+1)'(vt_pkg::HDR_BYTES);
		if (opc >= vt_pkg::CUSTOM_BASE) begin
			p = p + (IW+1)'(1);
		end
		if (flags[vt_pkg::FLG_ADDR]) begin
			p = p + (IW+1)'(vt_pkg::UID_BYTES);
		end
		blk  = bt(p);
		wdat = {bt(p + (IW+1)'(4)), bt(p + (IW+1)'(3)), bt(p + (IW+1)'(2)), bt(p + (IW+1)'(1))};
	end

	// [RL1] [RL2] [RL3] [RL4] [RL5] opcode class
	assign op       = vt_pkg::op_class(opc);
	assign in_range = (blk < 8'(NUM_BLOCKS));
	assign locked   = in_range && lock_q[blk[LBW-1:0]];
	// [RL15] [RL16] page protection only outside secure mode
	assign wp       = !secure_q && prot_q[{blk[LBW-1:2], 1'b1}];
	assign rp       = !secure_q && prot_q[{blk[LBW-1:2], 1'b0}];
	// [RL23] residue over data and CRC bytes
	assign crc_ok   = (rx_crc == vt_pkg::CRC_RESIDUE);
	assign accept   = crc_ok && (cnt_q >= (IW+1)'(vt_pkg::MIN_FRAME)) && (op != vt_pkg::OP_NONE)
		&& (secure_q || !vt_pkg::sec_only(opc));

	// Request byte capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			for (int i = 0; i < vt_pkg::RX_DEPTH; i++) begin
				buf_q[i] <= 8'h00;
			end
		end else if (rx_sof && (state_q == vt_pkg::ST_IDLE || state_q == vt_pkg::ST_RECV)) begin
			cnt_q <= '0;
		end else if (rx_valid && state_q == vt_pkg::ST_RECV
			&& cnt_q < (IW+1)'(vt_pkg::RX_DEPTH)) begin
			buf_q[cnt_q[IW-1:0]] <= rx_byte;
			cnt_q                <= cnt_q + (IW+1)'(1);
		end
	end

	vt_crc16 u_rx_crc (
		.pclk    (pclk),
		.presetn (presetn),
		.init    (rx_sof),
		.en      (rx_valid && state_q == vt_pkg::ST_RECV),
		.din     (rx_byte),
		.crc     (rx_crc)
	);

	// ****************************************
	// Command execution
	// ****************************************
	// Error check, programming time and answer frame
	always_comb begin
		err_d  = 1'b0;
		code_d = 8'h00;
		prog_d = 32'd0;
		flen_d = 3'd1;
		crc_d  = vt_pkg::CRC_INIT;
		for (int i = 0; i < vt_pkg::FRAME_MAX; i++) begin
			frame_d[i] = 8'h00;
		end
		unique case (op)
			vt_pkg::OP_WRITE: begin
				// [RL14] [RL15] locks first, then page protection
				if (!in_range) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_RANGE};
				end else if (locked) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_LOCKED};
				end else if (wp) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_GENERIC};
				end
				prog_d = 32'(WR_CYC);
			end
			vt_pkg::OP_LOCK: begin
				if (!in_range) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_RANGE};
				end else if (wp) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_GENERIC};
				end else if (locked) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_ALREADY};
				end
				prog_d = 32'(LOCK_CYC);
			end
			vt_pkg::OP_READ: begin
				if (!in_range) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_RANGE};
				end else begin
					// Read-protected pages return zeros
					{frame_d[4], frame_d[3], frame_d[2], frame_d[1]} = rp ? 32'h0 : mem_rdata;
					flen_d = 3'd5;
				end
			end
			vt_pkg::OP_WAFI: begin
				if (afi_lk_q && !secure_q) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_LOCKED};
				end
				prog_d = 32'(WAFI_CYC);
			end
			vt_pkg::OP_LAFI: begin
				if (afi_lk_q) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_ALREADY};
				end
				prog_d = 32'(LAFI_CYC);
			end
			vt_pkg::OP_WDSF: begin
				if (dsf_lk_q) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_LOCKED};
				end
				prog_d = 32'(WDSF_CYC);
			end
			vt_pkg::OP_LDSF: begin
				if (dsf_lk_q) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_ALREADY};
				end
				prog_d = 32'(LDSF_CYC);
			end
			vt_pkg::OP_PROG: prog_d = 32'(EAS_CYC);
			vt_pkg::OP_PROT: begin
				if (blk >= 8'(PROT_W / 2)) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_RANGE};
				end
			end
			vt_pkg::OP_LOGIN: begin
				if ({bt(p + (IW+1)'(3)), bt(p + (IW+1)'(2)),
					bt(p + (IW+1)'(1)), blk} != pwd_q) begin
					{err_d, code_d} = {1'b1, vt_pkg::ERR_GENERIC};
				end
			end
			vt_pkg::OP_PLAIN, vt_pkg::OP_NONE: begin
			end
		endcase
		// [RL8] error flag and error code byte
		// [RL7] flags, parameters, then inverted CRC low byte first
		frame_d[0] = {7'h00, err_d};
		if (err_d) begin
			frame_d[1] = code_d;
			flen_d     = 3'd2;
		end
		for (int i = 0; i < vt_pkg::FRAME_MAX - 2; i++) begin
			if (3'(i) < flen_d) begin
				crc_d = vt_pkg::crc_byte(crc_d, frame_d[i]);
			end
		end
		frame_d[flen_d]        = ~crc_d[7:0];
		frame_d[flen_d + 3'd1] = ~crc_d[15:8];
		flen_d                 = flen_d + 3'd2;
	end

	assign exec_ok = (state_q == vt_pkg::ST_EXEC) && !err_d;

	vt_prog_timer #(
		.W (32)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		// [RL11] [RL17] [RL19] [RL20] [RL21] wait before answering
		.load    (exec_ok && prog_d != 32'd0 && !opt),
		.count   (prog_d),
		.done    (tmr_done),
		.busy    ()
	);

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= vt_pkg::ST_IDLE;
		end else begin
			unique case (state_q)
				vt_pkg::ST_IDLE: if (rx_sof) state_q <= vt_pkg::ST_RECV;
				vt_pkg::ST_RECV: begin
					// [RL23] [RL10] bad CRC or unsupported: stay silent
					if (rx_eof) begin
						state_q <= accept ? vt_pkg::ST_EXEC : vt_pkg::ST_IDLE;
					end
				end
				vt_pkg::ST_EXEC: begin
					// [RL13] option flag: hold answer for the reader's EOF
					if (!exec_ok || prog_d == 32'd0) begin
						state_q <= vt_pkg::ST_SEND;
					end else begin
						state_q <= opt ? vt_pkg::ST_EOF : vt_pkg::ST_PROG;
					end
				end
				vt_pkg::ST_PROG: if (tmr_done) state_q <= vt_pkg::ST_SEND;
				vt_pkg::ST_EOF:  if (rx_eof) state_q <= vt_pkg::ST_SEND;
				vt_pkg::ST_SEND: if (tx_ready && tx_last) state_q <= vt_pkg::ST_IDLE;
			endcase
		end
	end

	// Answer frame and byte output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flen_q    <= 3'd0;
			idx_q     <= 3'd0;
			tx_byte_q <= 8'h00;
			for (int i = 0; i < vt_pkg::FRAME_MAX; i++) begin
				frame_q[i] <= 8'h00;
			end
		end else if (state_q == vt_pkg::ST_EXEC) begin
			frame_q   <= frame_d;
			flen_q    <= flen_d;
			idx_q     <= 3'd0;
			tx_byte_q <= frame_d[0];
		end else if (tx_valid && tx_ready && !tx_last) begin
			idx_q     <= idx_q + 3'd1;
			tx_byte_q <= frame_q[idx_q + 3'd1];
		end
	end

	assign tx_valid = (state_q == vt_pkg::ST_SEND);
	assign tx_last  = tx_valid && (idx_q == flen_q - 3'd1);
	assign tx_byte  = tx_byte_q;

	// [RL22] secure mode kept except on login
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			secure_q <= 1'b0;
		end else if (state_q == vt_pkg::ST_EXEC && op == vt_pkg::OP_LOGIN) begin
			secure_q <= !err_d;
		end
	end

	// Persistent tag state changed by commands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_q   <= '0;
			afi_q    <= vt_pkg::AFI_RST;
			dsfid_q  <= vt_pkg::DSFID_RST;
			afi_lk_q <= 1'b0;
			dsf_lk_q <= 1'b0;
		end else if (exec_ok) begin
			if (op == vt_pkg::OP_LOCK) lock_q[blk[LBW-1:0]] <= 1'b1;
			if (op == vt_pkg::OP_WAFI) afi_q <= blk;
			if (op == vt_pkg::OP_LAFI) afi_lk_q <= 1'b1;
			if (op == vt_pkg::OP_WDSF) dsfid_q <= blk;
			if (op == vt_pkg::OP_LDSF) dsf_lk_q <= 1'b1;
		end
	end

	// Block memory port and last-command status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_addr    <= 8'h00;
			mem_we_q    <= 1'b0;
			mem_wdata   <= 32'h0;
			last_op_q   <= 8'h00;
			last_code_q <= 8'h00;
			last_err_q  <= 1'b0;
		end else begin
			if (state_q == vt_pkg::ST_RECV && rx_eof) mem_addr <= blk;
			mem_we_q <= exec_ok && op == vt_pkg::OP_WRITE;
			if (state_q == vt_pkg::ST_EXEC) begin
				mem_wdata   <= wdat;
				last_op_q   <= opc;
				last_code_q <= code_d;
				last_err_q  <= err_d;
			end
		end
	end

	assign mem_we = mem_we_q;

	// ****************************************
	// APB registers
	// ****************************************
	assign apb_wr    = psel && penable && pwrite;
	assign apb_setup = psel && !penable;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !hit(paddr);
	assign prdata    = prdata_q;

	// Password and page protection; a command wins over software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwd_q  <= vt_pkg::PWD_RST;
			prot_q <= '0;
		end else begin
			if (apb_wr && paddr == vt_pkg::OFF_PWD) pwd_q <= pwdata;
			if (exec_ok && op == vt_pkg::OP_PROT) begin
				prot_q[{blk[LBW-3:0], 1'b0} +: 2] <= 2'(bt(p + (IW+1)'(1)));
			end else if (apb_wr && paddr == vt_pkg::OFF_PROT) begin
				prot_q <= pwdata[PROT_W-1:0];
			end
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (apb_setup && !pwrite) begin
			unique case (paddr)
				vt_pkg::OFF_STATUS: prdata_q <= {8'h00, last_op_q, last_code_q, 5'h00,
					last_err_q, state_q != vt_pkg::ST_IDLE, secure_q};
				vt_pkg::OFF_LOCKS:  prdata_q <= 32'(lock_q);
				vt_pkg::OFF_PROT:   prdata_q <= 32'(prot_q);
				vt_pkg::OFF_IDENT:  prdata_q <= {14'h0, dsf_lk_q, afi_lk_q, dsfid_q, afi_q};
				default:            prdata_q <= 32'h0;
			endcase
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_len_q <= 32'd0;
			wait_cnt_q <= 32'd0;
		end else if (state_q == vt_pkg::ST_EXEC) begin
			prog_len_q <= prog_d;
			wait_cnt_q <= 32'd0;
		end else if (state_q == vt_pkg::ST_PROG) begin
			wait_cnt_q <= wait_cnt_q + 32'd1;
		end
	end

	sequence s_eof_bad;
		state_q == vt_pkg::ST_RECV && rx_eof && !crc_ok;
	endsequence
	sequence s_exec(vt_pkg::vt_op_type k);
		state_q == vt_pkg::ST_EXEC && op == k;
	endsequence

	a_crc_drop: assert property (s_eof_bad |=> state_q == vt_pkg::ST_IDLE && $stable(lock_q)) // RL23
		else $error("bad CRC frame was not dropped");
	a_login_bad: assert property (s_exec(vt_pkg::OP_LOGIN) ##0 err_d |=> !secure_q) // RL22
		else $error("wrong password kept secure mode");
	a_secure_kept: assert property (secure_q // RL22
		&& !(state_q == vt_pkg::ST_EXEC && op == vt_pkg::OP_LOGIN) |=> secure_q)
		else $error("secure mode lost outside login");
	a_locked_write: assert property (s_exec(vt_pkg::OP_WRITE) ##0 locked |=> frame_q[0][0]) // RL14
		else $error("write to locked block not flagged");
	a_page_write: assert property (s_exec(vt_pkg::OP_WRITE) ##0 (in_range && !locked
		&& !secure_q && prot_q[{blk[LBW-1:2], 1'b1}]) |=> frame_q[1] == vt_pkg::ERR_GENERIC) // RL15
		else $error("protected page write not flagged");
	a_secure_write: assert property (s_exec(vt_pkg::OP_WRITE) ##0 (secure_q && in_range && !locked)
		|=> !frame_q[0][0] && mem_we) // RL16
		else $error("secure write refused");
	a_prog_time: assert property (state_q == vt_pkg::ST_PROG && tmr_done
		|-> wait_cnt_q == prog_len_q - 32'd1) // RL11
		else $error("answer before programming time");
	a_eof_hold: assert property (state_q == vt_pkg::ST_EOF && !rx_eof |=> !tx_valid) // RL13
		else $error("option answer sent before EOF");
	a_flags_first: assert property ($rose(tx_valid) |-> tx_byte == frame_q[0]
		&& tx_byte[vt_pkg::FLG_ERR] == last_err_q) // RL7
		else $error("answer does not open with flags");
	a_inventory: assert property (state_q == vt_pkg::ST_RECV && rx_eof && crc_ok
		&& opc == vt_pkg::OPC_INVENTORY && cnt_q >= (IW+1)'(vt_pkg::MIN_FRAME)
		|=> state_q == vt_pkg::ST_EXEC) // RL10
		else $error("inventory not accepted");

endmodule

`default_nettype wire

// >>> testbench/vt_reader.sv
`default_nettype none
// Reader model: frames requests, takes answers with a stall per byte
module vt_reader (
	input  wire logic       pclk,                     // Clock
	output logic            rx_sof, rx_valid, rx_eof, // Frame strobes
	output logic      [7:0] rx_byte,                  // Request byte
	input  wire logic       tx_valid, tx_last,        // Answer strobes
	input  wire logic [7:0] tx_byte,                  // Answer byte
	output logic            tx_ready                  // Byte taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ans[$];
	int         lat;
	// Quiet lines at start
	initial {rx_sof, rx_valid, rx_eof, tx_ready, rx_byte} = '0;
	// Frame check, one byte
	function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
		c ^= {8'h00, d};
		repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		return c;
	endfunction
	task automatic send(input logic [7:0] b[$], input logic bad, input int lim);
		logic [15:0] c = 16'hffff;
		foreach (b[i]) c = crc(c, b[i]);
		b.push_back(~c[7:0] ^ {7'h0, bad});
		b.push_back(~c[15:8]);
		@(posedge pclk) rx_sof <= 1'b1;
		foreach (b[i]) begin
			@(posedge pclk) rx_sof <= 1'b0;
			rx_valid <= 1'b1;
			rx_byte <= b[i];
		end
		@(posedge pclk) rx_valid <= 1'b0;
		rx_byte <= ~rx_byte;
		eof();
		recv(lim);
	endtask
	// Frame end, also the later option end
	task automatic eof();
		@(posedge pclk) rx_eof <= 1'b1;
		@(posedge pclk) rx_eof <= 1'b0;
	endtask
	task automatic recv(input int lim);
		logic l;
		ans = {};
		lat = 0;
		do begin
			@(negedge pclk);
			lat++;
		end while (tx_valid !== 1'b1 && lat < lim);
		while (tx_valid === 1'b1) begin
			ans.push_back(tx_byte);
			l = tx_last;
			@(posedge pclk) tx_ready <= 1'b1;
			@(posedge pclk) tx_ready <= 1'b0;
			if (l === 1'b1) break;
			@(negedge pclk);
		end
	endtask
endmodule
`default_nettype wire

// >>> testbench/vt_cmd_core_test.sv
`default_nettype none
// Bench: register bus and request link driven by tasks
module vt_cmd_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic rx_sof, rx_valid, rx_eof, tx_valid, tx_last, tx_ready, mem_we;
	logic [7:0] paddr, rx_byte, tx_byte, mem_addr, q[$], d[$] = '{8'h44, 8'h33, 8'h22, 8'h11};
	logic [31:0] pwdata, prdata, rd, mem_wdata, mem [32];
	wire logic [31:0] mem_rdata = mem[mem_addr[4:0]];
	int num_errors = 0, n_compared = 0, cyc [7] = '{4, 5, 6, 7, 8, 9, 3};
	logic [7:0] opc [7] = '{8'h21, 8'h22, 8'h27, 8'h28, 8'h29, 8'h2a, 8'ha2};
	logic [7:0] arg [7] = '{8'h00, 8'h01, 8'h5a, 8'h00, 8'ha5, 8'h00, 8'h00};
	logic [7:0] pl [7] = '{8'h01, 8'h23, 8'h2b, 8'h2c, 8'hc3, 8'hb8, 8'hb0};
	logic [7:0] oa [3] = '{8'h04, 8'h03, 8'h77};
	vt_cmd_core #(.WR_CYC(4), .LOCK_CYC(5), .WAFI_CYC(6), .LAFI_CYC(7), .WDSF_CYC(8),
		.LDSF_CYC(9), .EAS_CYC(3)) u_vt_cmd_core (.*);
	vt_reader u_vt_reader (.*);
	// Clock and block store
	always #4 pclk = ~pclk;
	always @(posedge pclk) if (mem_we) mem[mem_addr[4:0]] <= mem_wdata;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One request; flags ff means no answer expected
	task automatic rq(input logic [7:0] b[$], f, e = 0, input logic bad = 0);
		logic [15:0] c = 16'hffff;
		u_vt_reader.send(b, bad, 40);
		q = u_vt_reader.ans;
		foreach (q[i]) c = u_vt_reader.crc(c, q[i]);
		if (f == 8'hff) chk("silent", 0, q.size());
		else chk("residue", 16'hf0b8, c);
		if (f != 8'hff) chk("flags", f, q[0]);
		if (f[0] && f != 8'hff) chk("code", e, q[1]);
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] dw);
		int t = 0;
		@(posedge pclk) paddr <= a;
		pwrite <= w;
		pwdata <= dw;
		psel <= 1'b1;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk) t++; while (pready !== 1'b1 && t < 9);
		if (pready !== 1'b1) num_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		close_out();
	end
	// Test sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		mem = '{default: '0};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		foreach (opc[i]) begin
			rq({8'h00, opc[i], arg[i], d}, 8'h00);
			chk("latency", cyc[i] + 2, u_vt_reader.lat);
		end
		rq({8'h00, 8'h20, 8'h00}, 8'h00);
		chk("read data", 32'h11223344, {q[4], q[3], q[2], q[1]});
		rq({8'h00, 8'h21, 8'h01, d}, 8'h01, 8'h12);
		rq({8'h00, 8'h21, 8'h05, d}, 8'hff, 8'h00, 1'b1);
		rq({8'h00, 8'h20, 8'h05}, 8'h00);
		chk("kept data", 0, {q[4], q[3], q[2], q[1]});
		apb(8'h10, 0, 0);
		chk("ident", 32'h0003a55a, rd);
		apb(8'h40, 0, 0);
		chk("unmapped", 1, err);
		apb(8'h0c, 1, 32'h2);
		rq({8'h00, 8'h21, 8'h02, d}, 8'h01, 8'h0f);
		rq({8'h00, 8'hb4, 8'h00, d}, 8'hff);
		foreach (pl[i]) rq({8'h00, pl[i], 8'h00, 8'h00, 8'h00}, 8'h00);
		$display("test normal mode done");
		rq({8'h00, 8'he4, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h00);
		apb(8'h00, 0, 0);
		chk("secure", 1, rd[0]);
		rq({8'h00, 8'h21, 8'h02, d}, 8'h00);
		rq({8'h00, 8'h21, 8'h01, d}, 8'h01, 8'h12);
		for (int i = 0; i < 3; i++) begin
			u_vt_reader.send({8'h40, opc[i], oa[i], d}, 0, 12);
			chk("held", 0, u_vt_reader.ans.size());
			u_vt_reader.eof();
			u_vt_reader.recv(20);
			chk("released", 0, u_vt_reader.ans[0]);
		end
		rq({8'h00, 8'he4, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00}, 8'h01, 8'h0f);
		apb(8'h00, 0, 0);
		chk("status", 32'h00e40f04, rd);
		apb(8'h08, 0, 0);
		chk("locks", 32'h0000000a, rd);
		$display("test secure mode done");
		close_out();
	end
endmodule
`default_nettype wire
